/* hw/tmc_timer.v */
// Purpose: 16-bit timer counter, buffered modulo and one channel status/control
// Assumes: 8-bit register port, read data one cycle after the read strobe
// Notes: channel value is a plain register here, without byte coherency
//
// Function
// - reading either counter byte latches both; buffer kept until other byte read
// - counter read latch idles on reset and on timer status/control write
// - reset or any counter byte write zeroes counter and its read latch
// - debug halt freezes counter and read latch state
// - in debug halt, status/control or counter writes still reset read latch
// - with center-aligned off, at modulo value counter wraps to zero and sets overflow flag
// - one modulo byte written suppresses overflow flag until other byte written
// - modulo resets to zero; zero modulo means free running
// - modulo writes buffered; with clock stopped, loaded on second byte
// - with clock running, load at step to modulo, or 0xFFFE to 0xFFFF
// - status/control write resets modulo write sequence
// - debug halt freezes modulo sequence; modulo writes go straight in
// - input capture sets channel flag on the selected active edge
// - compare and PWM set flag on match, not at 0% or 100% duty
// - channel request raised while flag and channel enable set
// - flag cleared by read-while-set then write 0; new event keeps it set
// - reset clears channel flag and channel enable
// - mode b with center-aligned off selects edge-aligned PWM
// - with mode b and center-aligned clear, mode a picks capture or compare
// - edge/level field picks edge, compare action or polarity; 00 releases pin
// - capture codes 01 rising, 10 falling, 11 both edges
// - compare codes 00 software, 01 toggle, 10 clear, 11 set
// - clock select 00 stop, 01 bus, 10 fixed, 11 external
//
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/1ns
`include "tmc_map.vh"
module tmc_timer (
   input wire clk_sys,
   input wire rst_n,
   input wire [2:0] regAddr,
   input wire [7:0] regWrData,
   input wire regWrStb,
   input wire regRdStb,
   output reg [7:0] regRdData,
   input wire debugHalt,
   input wire fixedClkTick,
   input wire extClkPin,
   input wire chanPinIn,
   output wire chanPinOut,
   output wire chanPinOe,
   output wire overflowIrq,
   output wire chanIrq
);

   // ------------------------------------------------------------
   // input synchronisers
   // ------------------------------------------------------------
   reg [2:0] syncA_q;
   reg [2:0] syncB_q;
   reg extPrev_q;
   reg pinPrev_q;
   wire fixedS = syncB_q[0];
   wire extS = syncB_q[1];
   wire pinS = syncB_q[2];
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi = gi + 1) begin : gSync
         always @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
               syncA_q[gi] <= 1'b0;
               syncB_q[gi] <= 1'b0;
            end else begin
               syncA_q[gi] <= (gi == 0) ? fixedClkTick : (gi == 1) ? extClkPin : chanPinIn;
               syncB_q[gi] <= syncA_q[gi];
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   reg ovfFlag_q, ovfIe_q, cpwm_q;
   reg [1:0] clkSel_q;
   reg [2:0] presc_q;
   reg [15:0] cnt_q;
   reg cntUp_q;
   reg [15:0] cntBuf_q;
   reg cntLatched_q;
   reg cntLatchHigh_q;
   reg [15:0] mod_q;
   reg [15:0] modBuf_q;
   reg modHiWr_q, modLoWr_q;
   reg [6:0] prescCnt_q;
   reg chFlag_q, chIe_q, chMsb_q, chMsa_q, chElb_q, chEla_q;
   reg [15:0] chVal_q;
   reg ovfRdArm_q, chRdArm_q;
   reg pinOut_q;

   wire wrTsc = regWrStb && regAddr == `TMC_ADDR_TSC;
   wire wrCnt = regWrStb && (regAddr == `TMC_ADDR_CNTH || regAddr == `TMC_ADDR_CNTL);
   wire wrModH = regWrStb && regAddr == `TMC_ADDR_MODH;
   wire wrModL = regWrStb && regAddr == `TMC_ADDR_MODL;
   wire wrCsc = regWrStb && regAddr == `TMC_ADDR_CSC;
   wire rdCntH = regRdStb && regAddr == `TMC_ADDR_CNTH;
   wire rdCntL = regRdStb && regAddr == `TMC_ADDR_CNTL;

   // ------------------------------------------------------------
   // clock select and prescaler
   // ------------------------------------------------------------
   reg srcTick;
   always @* begin
      case (clkSel_q)
         `TMC_CLK_STOP: srcTick = 1'b0;
         `TMC_CLK_BUS: srcTick = 1'b1;
         `TMC_CLK_FIXED: srcTick = fixedS;
         `TMC_CLK_EXT: srcTick = extS && !extPrev_q;
         default: srcTick = 1'b0;
      endcase
   end
   wire [6:0] prescMax = (7'h01 << presc_q) - 7'h01;
   // one step per prescaler terminal count, never while halted
   wire step = srcTick && !debugHalt && prescCnt_q >= prescMax;
   wire modOn = mod_q != `TMC_RST_WORD;
   wire [15:0] topVal = modOn ? mod_q : `TMC_CNT_FREE_LAST;
   wire modPending = modHiWr_q ^ modLoWr_q;
   wire modReady = modHiWr_q && modLoWr_q;
   // up/down count only in center-aligned mode; overflow at the bottom there
   wire atTop = cnt_q == topVal;
   wire atBot = cnt_q == `TMC_RST_WORD;
   wire wrap = step && (cpwm_q ? (!cntUp_q && atBot && modOn) : atTop);
   wire [15:0] nextCnt = cpwm_q ? (cntUp_q ? (atTop ? cnt_q - 16'h0001 : cnt_q + 16'h0001)
      : (atBot ? cnt_q + 16'h0001 : cnt_q - 16'h0001))
      : (atTop ? `TMC_RST_WORD : cnt_q + 16'h0001);
   wire toTop = step && (cnt_q + 16'h0001 == topVal) && (!cpwm_q || cntUp_q);
   // overflow suppressed mid modulo update
   wire ovfEvent = wrap && !modPending;

   // ------------------------------------------------------------
   // channel mode decode and events
   // ------------------------------------------------------------
   wire [1:0] els = {chElb_q, chEla_q};
   wire modeCap = !cpwm_q && !chMsb_q && !chMsa_q;
   wire modeCmp = !cpwm_q && !chMsb_q && chMsa_q;
   wire modePwm = cpwm_q || chMsb_q;
   wire pinRise = pinS && !pinPrev_q;
   wire pinFall = !pinS && pinPrev_q;
   wire capHit = modeCap && ((chEla_q && pinRise) || (chElb_q && pinFall));
   wire match = step && nextCnt == chVal_q;
   // 0% and 100% duty have no match worth flagging
   wire dutyEdge = chVal_q == `TMC_RST_WORD || chVal_q > topVal;
   wire cmpHit = match && (modeCmp || (modePwm && !dutyEdge));
   wire chEvent = capHit || cmpHit;

   assign overflowIrq = ovfFlag_q && ovfIe_q;
   assign chanIrq = chFlag_q && chIe_q;
   assign chanPinOe = els != 2'h0 && !modeCap;
   assign chanPinOut = pinOut_q;

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         extPrev_q <= 1'b0;
         pinPrev_q <= 1'b0;
         cnt_q <= `TMC_RST_WORD;
         cntUp_q <= 1'b1;
         prescCnt_q <= 7'h00;
      end else begin
         extPrev_q <= extS;
         pinPrev_q <= pinS;
         if (clkSel_q == `TMC_CLK_STOP || wrCnt)
            prescCnt_q <= 7'h00;
         else if (srcTick && !debugHalt)
            prescCnt_q <= (prescCnt_q >= prescMax) ? 7'h00 : prescCnt_q + 7'h01;
         // counter
         if (wrCnt) begin
            cnt_q <= `TMC_RST_WORD;
            cntUp_q <= 1'b1;
         end else if (step) begin
            cnt_q <= nextCnt;
            if (cpwm_q && (atTop || atBot))
               cntUp_q <= atBot;
         end
      end
   end

   // ------------------------------------------------------------
   // counter read latch
   // ------------------------------------------------------------
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cntBuf_q <= `TMC_RST_WORD;
         cntLatched_q <= 1'b0;
         cntLatchHigh_q <= 1'b0;
      end else begin
         // halt freezes the latch; a write still frees it
         if (wrTsc || wrCnt) begin
            cntLatched_q <= 1'b0;
         end else if (!debugHalt && (rdCntH || rdCntL)) begin
            if (!cntLatched_q) begin
               cntLatched_q <= 1'b1;
               cntBuf_q <= cnt_q;
               cntLatchHigh_q <= rdCntH;
            end else if (cntLatchHigh_q != rdCntH) begin
               cntLatched_q <= 1'b0;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // modulo write buffer
   // ------------------------------------------------------------
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         mod_q <= `TMC_RST_WORD;
         modBuf_q <= `TMC_RST_WORD;
         modHiWr_q <= 1'b0;
         modLoWr_q <= 1'b0;
      end else begin
         // halted writes bypass the buffer and leave the sequence alone
         if (wrTsc) begin
            modHiWr_q <= 1'b0;
            modLoWr_q <= 1'b0;
         end else if (debugHalt) begin
            if (wrModH)
               mod_q[15:8] <= regWrData;
            if (wrModL)
               mod_q[7:0] <= regWrData;
         end else begin
            if (wrModH) begin
               modBuf_q[15:8] <= regWrData;
               modHiWr_q <= 1'b1;
            end
            if (wrModL) begin
               modBuf_q[7:0] <= regWrData;
               modLoWr_q <= 1'b1;
            end
            if (modReady && (clkSel_q == `TMC_CLK_STOP || toTop)) begin
               mod_q <= modBuf_q;
               modHiWr_q <= 1'b0;
               modLoWr_q <= 1'b0;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // timer status/control
   // ------------------------------------------------------------
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ovfFlag_q <= 1'b0;
         ovfIe_q <= 1'b0;
         cpwm_q <= 1'b0;
         clkSel_q <= `TMC_CLK_STOP;
         presc_q <= 3'h0;
         ovfRdArm_q <= 1'b0;
      end else begin
         // overflow flag set wins over clear
         if (regRdStb && regAddr == `TMC_ADDR_TSC)
            ovfRdArm_q <= ovfFlag_q;
         if (ovfEvent) begin
            ovfFlag_q <= 1'b1;
            ovfRdArm_q <= 1'b0;
         end else if (wrTsc && ovfRdArm_q && !regWrData[`TMC_TSC_FLAG]) begin
            ovfFlag_q <= 1'b0;
            ovfRdArm_q <= 1'b0;
         end
         if (wrTsc) begin
            ovfIe_q <= regWrData[`TMC_TSC_IE];
            cpwm_q <= regWrData[`TMC_TSC_CPWM];
            clkSel_q <= {regWrData[`TMC_TSC_CLKB], regWrData[`TMC_TSC_CLKA]};
            presc_q <= regWrData[2:0];
         end
      end
   end

   // ------------------------------------------------------------
   // channel status/control
   // ------------------------------------------------------------
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         chFlag_q <= 1'b0;
         chIe_q <= 1'b0;
         chMsb_q <= 1'b0;
         chMsa_q <= 1'b0;
         chElb_q <= 1'b0;
         chEla_q <= 1'b0;
         chRdArm_q <= 1'b0;
      end else begin
         // new event beats a pending clear
         if (regRdStb && regAddr == `TMC_ADDR_CSC)
            chRdArm_q <= chFlag_q;
         if (chEvent) begin
            chFlag_q <= 1'b1;
            chRdArm_q <= 1'b0;
         end else if (wrCsc && chRdArm_q && !regWrData[`TMC_CSC_FLAG]) begin
            chFlag_q <= 1'b0;
            chRdArm_q <= 1'b0;
         end
         if (wrCsc) begin
            chIe_q <= regWrData[`TMC_CSC_IE];
            chMsb_q <= regWrData[`TMC_CSC_MSB];
            chMsa_q <= regWrData[`TMC_CSC_MSA];
            chElb_q <= regWrData[`TMC_CSC_ELB];
            chEla_q <= regWrData[`TMC_CSC_ELA];
         end
      end
   end

   // ------------------------------------------------------------
   // channel value
   // ------------------------------------------------------------
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         chVal_q <= `TMC_RST_WORD;
      end else begin
         if (regWrStb && regAddr == `TMC_ADDR_CVH && !modeCap)
            chVal_q[15:8] <= regWrData;
         if (regWrStb && regAddr == `TMC_ADDR_CVL && !modeCap)
            chVal_q[7:0] <= regWrData;
         if (capHit)
            chVal_q <= cnt_q;
      end
   end

   // ------------------------------------------------------------
   // channel pin
   // ------------------------------------------------------------
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pinOut_q <= 1'b0;
      end else begin
         // compare actions first, PWM edges otherwise
         if (match && modeCmp) begin
            case (els)
               2'h1: pinOut_q <= !pinOut_q;
               2'h2: pinOut_q <= 1'b0;
               2'h3: pinOut_q <= 1'b1;
               default: pinOut_q <= pinOut_q;
            endcase
         end else if (modePwm && step) begin
            // high-true for 10, low-true for x1
            if (match && !(cpwm_q && !cntUp_q))
               pinOut_q <= chEla_q;
            else if (wrap || (cpwm_q && match))
               pinOut_q <= !chEla_q;
         end
      end
   end

   // ------------------------------------------------------------
   // read port; halted reads show the live frozen counter
   // ------------------------------------------------------------
   wire [15:0] cntView = (cntLatched_q && !debugHalt) ? cntBuf_q : cnt_q;
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         regRdData <= `TMC_RST_BYTE;
      end else if (regRdStb) begin
         case (regAddr)
            `TMC_ADDR_TSC: regRdData <= {ovfFlag_q, ovfIe_q, cpwm_q, clkSel_q, presc_q};
            `TMC_ADDR_CNTH: regRdData <= cntView[15:8];
            `TMC_ADDR_CNTL: regRdData <= cntView[7:0];
            `TMC_ADDR_MODH: regRdData <= mod_q[15:8];
            `TMC_ADDR_MODL: regRdData <= mod_q[7:0];
            `TMC_ADDR_CSC: regRdData <= {chFlag_q, chIe_q, chMsb_q, chMsa_q, els, 2'h0};
            `TMC_ADDR_CVH: regRdData <= chVal_q[15:8];
            `TMC_ADDR_CVL: regRdData <= chVal_q[7:0];
            default: regRdData <= `TMC_RST_BYTE;
         endcase
      end else begin
         regRdData <= `TMC_RST_BYTE;
      end
   end

endmodule

/* pkg/tmc_map.vh */
// Purpose: register offsets, field positions and reset values of the timer block
// Assumes: 8-bit register port, byte offsets
// Notes: definitions only
`ifndef TMC_MAP_VH
`define TMC_MAP_VH
`define TMC_ADDR_TSC 3'h0
`define TMC_ADDR_CNTH 3'h1
`define TMC_ADDR_CNTL 3'h2
`define TMC_ADDR_MODH 3'h3
`define TMC_ADDR_MODL 3'h4
`define TMC_ADDR_CSC 3'h5
`define TMC_ADDR_CVH 3'h6
`define TMC_ADDR_CVL 3'h7
`define TMC_TSC_FLAG 7
`define TMC_TSC_IE 6
`define TMC_TSC_CPWM 5
`define TMC_TSC_CLKB 4
`define TMC_TSC_CLKA 3
`define TMC_CSC_FLAG 7
`define TMC_CSC_IE 6
`define TMC_CSC_MSB 5
`define TMC_CSC_MSA 4
`define TMC_CSC_ELB 3
`define TMC_CSC_ELA 2
`define TMC_RST_BYTE 8'h00
`define TMC_RST_WORD 16'h0000
`define TMC_CNT_FREE_LAST 16'hFFFF
`define TMC_CNT_FREE_PRE 16'hFFFE
`define TMC_CLK_STOP 2'h0
`define TMC_CLK_BUS 2'h1
`define TMC_CLK_FIXED 2'h2
`define TMC_CLK_EXT 2'h3
`endif

/* test/tmc_timer_asserts.sv */
// Purpose: port-level checks of the timer counter, interrupt enables and channel control
// Assumes: one clock domain, asynchronous active-low reset
// Notes: control register shadows are rebuilt from bus writes
`timescale 1ns/1ns
module tmc_timer_asserts (
   input wire clk_sys,
   input wire rst_n,
   input wire [2:0] regAddr,
   input wire [7:0] regWrData,
   input wire regWrStb,
   input wire regRdStb,
   input wire [7:0] regRdData,
   input wire debugHalt,
   input wire chanPinOe,
   input wire overflowIrq,
   input wire chanIrq
);
   reg [7:0] tscShadow_q;
   reg [7:0] cscShadow_q;
   wire oeExp;
   // pin is ours unless the edge/level field is 00 or the channel captures
   assign oeExp = (cscShadow_q[3:2] != 2'h0) && (tscShadow_q[5] || cscShadow_q[5:4] != 2'h0);
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         tscShadow_q <= 8'h00;
         cscShadow_q <= 8'h00;
      end else if (regWrStb) begin
         if (regAddr == 3'h0) tscShadow_q <= regWrData;
         if (regAddr == 3'h5) cscShadow_q <= regWrData;
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // ----------
   // properties
   // ----------
   a_rd_idle: assert property (!regRdStb |=> regRdData == 8'h00)
      else $error("read data not idle");
   a_cnt_clr: assert property ((regWrStb && regAddr == 3'h1) ##2
      (regRdStb && regAddr == 3'h1) |=> regRdData == 8'h00) else $error("counter not cleared");
   a_halt_hold: assert property ((debugHalt && regRdStb && regAddr == 3'h2) ##1 debugHalt
      ##1 (debugHalt && regRdStb && regAddr == 3'h2) |=> regRdData == $past(regRdData, 2))
      else $error("counter moved in halt");
   a_coherent_rd: assert property ((regWrStb && regAddr == 3'h0 && !debugHalt) ##2
      (regRdStb && regAddr == 3'h2) ##2 (regRdStb && regAddr == 3'h2 && !debugHalt)
      |=> regRdData == $past(regRdData, 2)) else $error("low byte not held");
   a_oe_map: assert property (chanPinOe == oeExp)
      else $error("pin enable wrong");
   a_chan_irq_en: assert property (chanIrq |-> cscShadow_q[6])
      else $error("channel request while disabled");
   a_ovf_irq_en: assert property (overflowIrq |-> tscShadow_q[6])
      else $error("overflow request while disabled");
   a_chan_ie_off: assert property ((regWrStb && regAddr == 3'h5 && !regWrData[6])
      |=> !chanIrq) else $error("channel request survives disable");
   a_ovf_ie_off: assert property ((regWrStb && regAddr == 3'h0 && !regWrData[6])
      |=> !overflowIrq) else $error("overflow request survives disable");
endmodule
bind tmc_timer tmc_timer_asserts u_chk (.clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr),
   .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
   .debugHalt(debugHalt), .chanPinOe(chanPinOe), .overflowIrq(overflowIrq), .chanIrq(chanIrq));

/* test/tmc_timer_bench.sv */
// Purpose: self-checking bench for the timer counter, modulo and channel control
// Assumes: 50 MHz clock, read data one cycle after the strobe
// Notes: each read queues an expected byte and mask; a monitor compares them
`timescale 1ns/1ns
`define CHK(n, e, s) begin samples_checked++; if ((e) !== (s)) begin error_cnt++; \
   $display("mismatch %s expected %h seen %h", n, e, s); end end
module tmc_timer_bench;
   reg clk_sys = 1'b0;
   reg rst_n = 1'b0;
   reg [2:0] regAddr = 3'h0;
   reg [7:0] regWrData = 8'h00;
   reg regWrStb = 1'b0;
   reg regRdStb = 1'b0;
   reg debugHalt = 1'b0;
   reg fixedClkTick = 1'b0;
   reg extClkPin = 1'b0;
   reg chanPinIn = 1'b0;
   wire [7:0] regRdData;
   wire chanPinOut;
   wire chanPinOe;
   wire overflowIrq;
   wire chanIrq;
   int error_cnt = 0;
   int samples_checked = 0;
   integer seed = 33751;
   reg [31:0] rnd = 32'h0;
   reg rdSeen = 1'b0;
   logic fl;
   logic [7:0] e;
   logic [7:0] m;
   logic [7:0] expQ[$];
   logic [7:0] mskQ[$];
   tmc_timer u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
      .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData), .debugHalt(debugHalt),
      .fixedClkTick(fixedClkTick), .extClkPin(extClkPin), .chanPinIn(chanPinIn),
      .chanPinOut(chanPinOut), .chanPinOe(chanPinOe), .overflowIrq(overflowIrq),
      .chanIrq(chanIrq));
   always #10 clk_sys = ~clk_sys;
   // clock sources not selected still toggle, so stray counting would show
   always @(posedge clk_sys) begin
      rnd = $random(seed);
      fixedClkTick <= rnd[0];
      extClkPin <= rnd[1];
   end
   // -------
   // monitor
   // -------
   always @(posedge clk_sys) rdSeen <= regRdStb;
   always @(negedge clk_sys) begin
      if (rdSeen) begin
         e = expQ.pop_front();
         m = mskQ.pop_front();
         `CHK("regRdData", e, regRdData & m)
      end
   end
   task wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      regAddr <= a;
      regWrData <= d;
      regWrStb <= 1'b1;
      @(posedge clk_sys);
      regWrStb <= 1'b0;
   endtask
   task rd(input logic [2:0] a, input logic [7:0] x, input logic [7:0] k);
      @(posedge clk_sys);
      regAddr <= a;
      regRdStb <= 1'b1;
      expQ.push_back(x & k);
      mskQ.push_back(k);
      @(posedge clk_sys);
      regRdStb <= 1'b0;
   endtask
   task summarize;
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      #1900000;
      error_cnt++;
      summarize();
   end
   // --------
   // sequence
   // --------
   initial begin
      int n;
      repeat (5) @(posedge clk_sys);
      rst_n <= 1'b1;
      for (int a = 0; a < 6; a++) rd(a[2:0], 8'h00, 8'hFF);
      $display("test reset values done");
      wr(3'h1, 8'h00);
      wr(3'h3, 8'h00);
      wr(3'h4, 8'h1F);
      rd(3'h4, 8'h1F, 8'hFF);
      wr(3'h0, 8'h48);
      n = 0;
      while (overflowIrq !== 1'b1 && n < 300) begin
         @(posedge clk_sys);
         n++;
      end
      `CHK("overflow wait", 1'b1, (n < 300))
      for (int i = 0; i < 12; i++) begin
         rd(3'h1, 8'h00, 8'hFF);
         rd(3'h2, 8'h00, 8'hE0);
      end
      // stop first so no wrap can fall inside the clear sequence
      wr(3'h0, 8'hC0);
      rd(3'h0, 8'hC0, 8'hFF);
      wr(3'h0, 8'h40);
      rd(3'h0, 8'h40, 8'hFF);
      wr(3'h0, 8'hC0);
      rd(3'h0, 8'h40, 8'hFF);
      $display("test modulo wrap done");
      wr(3'h1, rnd[15:8]);
      rd(3'h1, 8'h00, 8'hFF);
      rd(3'h2, 8'h00, 8'hFF);
      wr(3'h0, 8'h08);
      wr(3'h3, 8'h00);
      repeat (100) @(posedge clk_sys);
      rd(3'h0, 8'h00, 8'h80);
      wr(3'h4, 8'h1F);
      repeat (100) @(posedge clk_sys);
      rd(3'h0, 8'h80, 8'h80);
      wr(3'h0, 8'h00);
      wr(3'h1, 8'h00);
      // undivided bus clock: one step per cycle from the enabling write
      wr(3'h0, 8'h08);
      rd(3'h2, 8'h01, 8'hFF);
      rd(3'h2, 8'h01, 8'hFF);
      debugHalt <= 1'b1;
      repeat (3) @(posedge clk_sys);
      rd(3'h2, 8'h04, 8'hFF);
      rd(3'h2, 8'h04, 8'hFF);
      debugHalt <= 1'b0;
      $display("test counter coherency done");
      wr(3'h0, 8'h00);
      wr(3'h1, 8'h00);
      wr(3'h0, 8'h0B);
      repeat (82) @(posedge clk_sys);
      wr(3'h0, 8'h00);
      rd(3'h1, 8'h00, 8'hFF);
      rd(3'h2, 8'h0A, 8'hFF);
      $display("test prescaler done");
      wr(3'h0, 8'h00);
      for (int i = 0; i < 16; i++) begin
         wr(3'h5, {2'b00, i[3:0], 2'b00});
         rd(3'h5, {2'b00, i[3:0], 2'b00}, 8'h7F);
      end
      wr(3'h0, 8'h20);
      wr(3'h5, 8'h04);
      wr(3'h0, 8'h00);
      $display("test channel modes done");
      for (int el = 1; el < 4; el++) begin
         wr(3'h5, {4'h4, el[1:0], 2'b00});
         for (int d = 0; d < 2; d++) begin
            chanPinIn <= ~chanPinIn;
            repeat (6) @(posedge clk_sys);
            fl = (el == 3) || (el == 1 && d == 0) || (el == 2 && d == 1);
            `CHK("chanIrq", fl, chanIrq)
            rd(3'h5, {fl, 3'h4, el[1:0], 2'b00}, 8'hFF);
            wr(3'h5, {4'h4, el[1:0], 2'b00});
         end
      end
      $display("test capture edges done");
      repeat (3) @(posedge clk_sys);
      summarize();
   end
endmodule
